// *** logic/parallel_port_io_lines.v ***
// Parallel port pin logic: latches, direction, open drain, alternate functions
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "port_io_defs.vh"

module parallel_port_io_lines #(
  parameter STATE_DIV = `STATE_DIV_DEF,
  parameter AW = 8,
  parameter DW = `PW
) (
  input wire mclk,
  input wire rst,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  input wire wr,
  input wire rd,
  output reg [DW-1:0] rdata,
  input wire [`NPINS-1:0] pin_in,
  output reg [`NPINS-1:0] pin_out,
  output reg [`NPINS-1:0] pin_oe,
  input wire [`NPINS-1:0] alt_en,
  input wire [`NPINS-1:0] alt_out,
  input wire [`NPINS-1:0] alt_pwm,
  input wire [`NPINS-1:0] alt_auto,
  input wire [`NPINS-1:0] alt_dir,
  output reg [`NPINS-1:0] alt_in,
  output reg [`THR_W-1:0] input_threshold_select
);

  reg [7:0] div_cnt;
  reg state_en;
  reg [`NPINS-1:0] sync1;
  reg [`NPINS-1:0] sync2;
  reg [`NPINS-1:0] in_latch;
  wire [`NPINS-1:0] out_latch;
  wire [`NPINS-1:0] pin_direction_bit;
  wire [`NPINS-1:0] open_drain_select;
  wire [`NPINS-1:0] view;
  wire [`NPINS-1:0] hw_dir;
  wire [`NPINS-1:0] eff_dir;
  wire [`NPINS-1:0] drv;
  reg [DW-1:0] next_rdata;
  integer i;

  // State time enable
  always @(posedge mclk) begin
    if (rst) begin
      div_cnt <= 8'h00;
      state_en <= 1'b0;
    end else if (div_cnt == STATE_DIV[7:0] - 8'h01) begin
      div_cnt <= 8'h00;
      state_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      state_en <= 1'b0;
    end
  end

  // Pin synchroniser and input latch, sampled regardless of direction
  always @(posedge mclk) begin
    if (rst) begin
      sync1 <= {`NPINS{1'b0}};
      sync2 <= {`NPINS{1'b0}};
      in_latch <= {`NPINS{1'b0}};
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      if (state_en) begin
        in_latch <= sync2 & `IMPL_MASK;
      end
    end
  end

  // Value seen by reads and by read-modify-write
  assign view = (pin_direction_bit & out_latch) | (~pin_direction_bit & in_latch);

  genvar p;
  generate
    for (p = 0; p < `NPORTS; p = p + 1) begin : g_port
      localparam [AW-1:0] PIDX = p;
      localparam [`NPINS-1:0] IMPL_ALL = `IMPL_MASK;
      localparam [`NPINS-1:0] DRV_ALL = `DRV_MASK;
      localparam [`NPINS-1:0] OD_ALL = `OD_MASK;
      localparam [DW-1:0] IMPL = IMPL_ALL[p*`PW +: `PW];
      localparam [DW-1:0] DRVM = DRV_ALL[p*`PW +: `PW];
      localparam [DW-1:0] ODM = OD_ALL[p*`PW +: `PW];
      localparam [AW-1:0] A_DATA = `DATA_BASE + PIDX;
      localparam [AW-1:0] A_DIR = `DIR_BASE + PIDX;
      localparam [AW-1:0] A_ODS = `ODS_BASE + PIDX;
      localparam [AW-1:0] A_SET = `SET_BASE + PIDX;
      localparam [AW-1:0] A_CLR = `CLR_BASE + PIDX;

      // One register bank per port
      port_bank #(
        .AW(AW),
        .DW(DW),
        .IMPL(IMPL),
        .DRVM(DRVM),
        .ODM(ODM),
        .A_DATA(A_DATA),
        .A_DIR(A_DIR),
        .A_ODS(A_ODS),
        .A_SET(A_SET),
        .A_CLR(A_CLR)
      ) port_bank_inst (
        .mclk(mclk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .cur(view[p*`PW +: `PW]),
        .latch(out_latch[p*`PW +: `PW]),
        .dir(pin_direction_bit[p*`PW +: `PW]),
        .ods(open_drain_select[p*`PW +: `PW])
      );
    end
  endgenerate

  // Threshold select, one bit per port byte
  always @(posedge mclk) begin
    if (rst) begin
      input_threshold_select <= `RST_THR;
    end else if (wr && addr == `THR_ADDR) begin
      input_threshold_select <= wdata[`THR_W-1:0];
    end
  end

  // Register read mux
  always @* begin
    next_rdata = {DW{1'b0}};
    for (i = 0; i < `NPORTS; i = i + 1) begin
      if (addr == `DATA_BASE + i[AW-1:0]) begin
        next_rdata = view[i*`PW +: `PW];
      end
      if (addr == `DIR_BASE + i[AW-1:0]) begin
        next_rdata = pin_direction_bit[i*`PW +: `PW];
      end
      if (addr == `ODS_BASE + i[AW-1:0]) begin
        next_rdata = open_drain_select[i*`PW +: `PW];
      end
    end
    if (addr == `THR_ADDR) begin
      next_rdata = {{(DW-`THR_W){1'b0}}, input_threshold_select};
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      rdata <= {DW{1'b0}};
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= {DW{1'b0}};
    end
  end

  // Hardware-steered direction for automatic alternate functions
  assign hw_dir = alt_auto & alt_en;
  assign eff_dir = ((hw_dir & alt_dir) | (~hw_dir & pin_direction_bit)) & `DRV_MASK;
  // Alternate data gated by latch unless PWM
  assign drv = (alt_en & ((alt_pwm & alt_out) | (~alt_pwm & alt_out & out_latch)))
    | (~alt_en & out_latch);

  // Pin drivers
  always @(posedge mclk) begin
    if (rst) begin
      pin_out <= {`NPINS{1'b0}};
      pin_oe <= {`NPINS{1'b0}};
      alt_in <= {`NPINS{1'b0}};
    end else begin
      pin_out <= drv & ~open_drain_select & eff_dir;
      pin_oe <= eff_dir & (~open_drain_select | ~drv);
      alt_in <= (pin_direction_bit & out_latch) | (~pin_direction_bit & in_latch);
    end
  end

endmodule // parallel_port_io_lines

// Register bank of one port: output latch, direction and driver mode
module port_bank #(
  parameter AW = 8,
  parameter DW = `PW,
  parameter [DW-1:0] IMPL = `RST_LATCH,
  parameter [DW-1:0] DRVM = `RST_DIR,
  parameter [DW-1:0] ODM = `RST_ODS,
  parameter [AW-1:0] A_DATA = `DATA_BASE,
  parameter [AW-1:0] A_DIR = `DIR_BASE,
  parameter [AW-1:0] A_ODS = `ODS_BASE,
  parameter [AW-1:0] A_SET = `SET_BASE,
  parameter [AW-1:0] A_CLR = `CLR_BASE
) (
  input wire mclk,
  input wire rst,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  input wire wr,
  input wire [DW-1:0] cur,
  output reg [DW-1:0] latch,
  output reg [DW-1:0] dir,
  output reg [DW-1:0] ods
);

  // Write decode for this port
  wire hit_data;
  wire hit_dir;
  wire hit_ods;
  wire hit_set;
  wire hit_clr;

  assign hit_data = wr && (addr == A_DATA);
  assign hit_dir = wr && (addr == A_DIR);
  assign hit_ods = wr && (addr == A_ODS);
  assign hit_set = wr && (addr == A_SET);
  assign hit_clr = wr && (addr == A_CLR);

  // Output latch: plain write or read-modify-write of the read view
  always @(posedge mclk) begin
    if (rst) begin
      latch <= `RST_LATCH;
    end else if (hit_data) begin
      latch <= wdata & IMPL;
    end else if (hit_set) begin
      latch <= (cur | wdata) & IMPL;
    end else if (hit_clr) begin
      latch <= cur & ~wdata & IMPL;
    end
  end

  // Direction, input after reset
  always @(posedge mclk) begin
    if (rst) begin
      dir <= `RST_DIR;
    end else if (hit_dir) begin
      dir <= wdata & DRVM;
    end
  end

  // Driver mode, only where open drain exists
  always @(posedge mclk) begin
    if (rst) begin
      ods <= `RST_ODS;
    end else if (hit_ods) begin
      ods <= wdata & ODM;
    end
  end

endmodule // port_bank

// *** logic/port_io_defs.vh ***
// Constants and register map for the parallel port pin logic
`ifndef PORT_IO_DEFS_VH
`define PORT_IO_DEFS_VH

`define NPORTS 9
`define PW 16
`define NPINS 144

`define DATA_BASE 8'h00
`define DIR_BASE 8'h10
`define ODS_BASE 8'h20
`define SET_BASE 8'h30
`define CLR_BASE 8'h40
`define THR_ADDR 8'h50

`define THR_W 14
`define STATE_DIV_DEF 2

`define RST_LATCH 16'h0000
`define RST_DIR 16'h0000
`define RST_ODS 16'h0000
`define RST_THR 14'h0000

// Port 8 in the top word, port 0 in the bottom word
`define IMPL_MASK 144'h00FF_00FF_00FF_FFFF_00FF_BFFF_FFFF_FFFF_FFFF
`define DRV_MASK 144'h00FF_00FF_00FF_0000_00FF_BFFF_FFFF_FFFF_FFFF
`define OD_MASK 144'h00FF_00FF_00FF_0000_00FF_BFFF_FFFF_0000_0000

`endif

// *** testbench/pin_world.sv ***
// Far-side pin model: pull-ups and external drivers
`timescale 1ns/1ps
module pin_world (
  input wire [143:0] pin_out,
  input wire [143:0] pin_oe,
  input wire [143:0] ext_val,
  input wire [143:0] ext_en,
  output wire [143:0] pin_in
);
  // Released lines float high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_en & ext_val | ~ext_en));
endmodule // pin_world

// *** testbench/port_chk.sv ***
// Checker for the port pin logic
`timescale 1ns/1ps
module port_chk (
  input wire mclk,
  input wire rst,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire [143:0] pin_out,
  input wire [143:0] pin_oe,
  input wire [143:0] alt_en,
  input wire [143:0] alt_auto,
  input wire [143:0] alt_dir,
  input wire [13:0] input_threshold_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_port5_off: assert property (pin_oe[95:80] == 16'h0000) else $error("p5 oe");
  a_port5_low: assert property (pin_out[95:80] == 16'h0000) else $error("p5 out");
  a_bit14_off: assert property (!pin_oe[62]) else $error("p3b14");
  a_release_low: assert property ((pin_out & ~pin_oe) == '0) else $error("out");
  a_reset_input: assert property ($fell(rst) |-> pin_oe == '0) else $error("rst");
  a_reset_thr: assert property ($fell(rst) |-> input_threshold_select == 14'h0000)
    else $error("thr");
  a_auto_dir: assert property (alt_en[0] && alt_auto[0] |=> pin_oe[0] == $past(alt_dir[0]))
    else $error("auto");
  a_dir_drive: assert property (wr && addr == 8'h12 && wdata[0] && !alt_en[32]
    |-> ##2 pin_oe[32]) else $error("dir");
  a_od_low: assert property (wr && addr == 8'h22 && wdata[1] |-> ##2 !pin_out[33])
    else $error("od");
  cover property (wr && addr == 8'h22);
  cover property (alt_en[0] && alt_auto[0]);
  cover property ($fell(rst));
endmodule // port_chk
bind parallel_port_io_lines port_chk port_chk_inst (.mclk, .rst, .addr, .wdata, .wr, .pin_out,
  .pin_oe, .alt_en, .alt_auto, .alt_dir, .input_threshold_select);

// *** testbench/tb.sv ***
// Testbench for the port pin logic
`timescale 1ns/1ps
module tb;
  logic mclk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  wire [15:0] rdata;
  wire [13:0] input_threshold_select;
  wire [143:0] pin_in, pin_out, pin_oe, alt_in;
  logic [143:0] alt_en = '0, alt_out = '0, alt_pwm = '0, alt_auto = '0, alt_dir = '0;
  logic [143:0] ext_val = '0, ext_en = '0;
  int n_errors = 0, compares = 0;
  always #2.5 mclk = ~mclk;
  parallel_port_io_lines parallel_port_io_lines_inst (.mclk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .pin_in, .pin_out, .pin_oe, .alt_en, .alt_out, .alt_pwm, .alt_auto, .alt_dir,
    .alt_in, .input_threshold_select);
  pin_world pin_world_inst (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);
  task chk(input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task wt(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge mclk);
    wr <= 0;
  endtask
  task rt(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1;
    @(posedge mclk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  task print_verdict;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #50000 n_errors++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 0;
    rt(8'h10, 16'h0000);
    ext_en[47:32] <= 16'hFFFF;
    ext_val[47:32] <= 16'hA5C3;
    wt(8'h02, 16'h1234);
    repeat (8) @(posedge mclk);
    rt(8'h02, 16'hA5C3);
    chk(pin_oe[47:32], 16'h0000);
    wt(8'h32, 16'h000F);
    wt(8'h12, 16'hFFFF);
    rt(8'h02, 16'hA5CF);
    chk(pin_out[47:32], 16'hA5CF);
    wt(8'h42, 16'h00F0);
    rt(8'h02, 16'hA50F);
    $display("latch test done");
    ext_en <= '0;
    wt(8'h50, 16'h3FFF);
    wt(8'h22, 16'hFFFF);
    rt(8'h22, 16'hFFFF);
    chk(pin_oe[47:32], 16'h5AF0);
    chk(pin_out[47:32], 16'h0000);
    chk({2'b00, input_threshold_select}, 16'h3FFF);
    wt(8'h13, 16'hFFFF);
    rt(8'h13, 16'hBFFF);
    wt(8'h15, 16'hFFFF);
    rt(8'h15, 16'h0000);
    wt(8'h20, 16'hFFFF);
    rt(8'h20, 16'h0000);
    rt(8'h60, 16'h0000);
    $display("mode test done");
    wt(8'h22, 16'h0000);
    alt_en <= {{79{1'b0}}, 1'b1, 27'h0, 5'h11, 32'h1};
    alt_out[64] <= 1;
    alt_out[36] <= 1;
    alt_pwm[36] <= 1;
    alt_auto[0] <= 1;
    alt_dir[0] <= 1;
    repeat (3) @(posedge mclk);
    #1 chk(pin_out[47:32], 16'hA51E);
    chk(alt_in[47:32], 16'hA50F);
    chk(pin_oe[15:0], 16'h0001);
    chk(pin_oe[79:64], 16'h0000);
    $display("alternate test done");
    print_verdict;
  end
endmodule // tb
